// ### core/bdr_pkg.sv
// bdr_pkg: constants shared by the bitmap display refresh controller.
// assumes a single 100 MHz core clock; pixel timing is derived by enables.
package bdr_pkg;

  // ----------------------------------------------------------------
  // clock rates
  // ----------------------------------------------------------------
  localparam int CORE_MHZ = 100;
  localparam int PIXEL_MHZ = 70;
  localparam logic [3:0] PIX_STEP = 4'(PIXEL_MHZ / 10);
  localparam logic [3:0] PIX_MOD = 4'(CORE_MHZ / 10);

  // ----------------------------------------------------------------
  // raster totals and pixel grouping
  // ----------------------------------------------------------------
  localparam int PIXELS_PER_LINE = 1344;
  localparam int LINES_PER_FRAME = 838;
  localparam int PIXELS_PER_CHAR = 16;
  localparam int LINES_PER_BLOCK = 8;
  localparam logic [6:0] H_TOTAL = 7'(PIXELS_PER_LINE / PIXELS_PER_CHAR);
  localparam logic [9:0] V_TOTAL = 10'(LINES_PER_FRAME);

  // ----------------------------------------------------------------
  // waveform positions, in characters and lines
  // ----------------------------------------------------------------
  localparam logic [6:0] H_ACTIVE = 7'h40;
  localparam logic [6:0] H_SYNC_START = 7'h44;
  localparam logic [6:0] H_SYNC_LEN = 7'h08;
  localparam logic [6:0] H_FETCH = 7'h48;
  localparam logic [9:0] V_ACTIVE = 10'h320;
  localparam logic [9:0] V_SYNC_START = 10'h323;
  localparam logic [9:0] V_SYNC_LEN = 10'h003;

  // ----------------------------------------------------------------
  // bus addresses and control register layout
  // ----------------------------------------------------------------
  localparam logic [23:0] DCR_ADDR = 24'hFFFA00;
  localparam logic [5:0] VMEM_TAG = 6'h38;
  localparam int DCR_OFF_BIT = 0;
  localparam int DCR_HALF_BIT = 1;
  localparam int DCR_INV_BIT = 2;
  localparam logic [2:0] DCR_RESET = 3'h0;

  // request handshake states
  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_WAIT = 2'b01,
    REQ_BUSY = 2'b10
  } bdr_req_e;

endpackage : bdr_pkg

// ### core/bdr_shifter.sv
// bdr_shifter: 16-bit parallel-load video shifter with serial fill input.
// assumes load and shift enables are one-cycle pulses in the core clock.
`timescale 1ns/1ns
module bdr_shifter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic shift,
  input wire logic [WIDTH-1:0] data,
  input wire logic fill,
  output logic serial_pixel
);

  logic [WIDTH-1:0] sreg;
  logic [WIDTH-1:0] next_sreg;

  // ----------------------------------------------------------------
  // next value: load wins over shift, msb leaves first
  // ----------------------------------------------------------------
  always_comb begin
    next_sreg = sreg;
    if (load) begin
      next_sreg = data;
    end else if (shift) begin
      next_sreg = {sreg[WIDTH-2:0], fill};
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (rst) begin
      sreg <= '0;
    end else begin
      sreg <= next_sreg;
    end
  end

  assign serial_pixel = sreg[WIDTH-1];

endmodule : bdr_shifter

// ### core/bdr_refresh.sv
// bdr_refresh: display refresh controller, video memory select and control register.
// assumes bus inputs are synchronous to CORE_CLK and the arbiter obeys
// the request/grant/clear handshake.
`timescale 1ns/1ns

// Notes on behaviour
// - outside grant, memory selected only when A23..A18 place the address in E00000..E3FFFF.
// - during grant the decoder is bypassed and data transceivers stay off.
// - line is 1344 pixels, frame is 838 lines, pixel rate 70 MHz.
// - a 4-bit pixel divider makes the char clock and shifter load.
// - horizontal count steps per 16 pixels; vertical count equals line number.
// - horizontal and vertical blanking from counters suppress video.
// - active-low horizontal and vertical sync decoded from counters.
// - fetch requests reload the VRAM shifter every 8 lines, block from row_count_bits.
// - vertical count clock steps lines; zero strobes clear counters at ends.
// - VRAM shift clock and half enables load the 16-bit shifter alternately.
// - serial pixel and blanking registered before blanking masks video.
// - inverse video bit set inverts the outgoing video.
// - request asserted when row and line fetch meet and display enabled.
// - request passes through a second flip-flop before the arbiter.
// - arbiter grants low and pulses clear low; request drops on clear.
// - during grant, row bits and half select drive address lines 10..17.
// - address bits 8,9 are zero in transfer; other bits are ignored.
// - during grant address valid is held high, select comes from grant.
// - transfer/output enable follows grant, else follows column strobe.
// - three-bit write-only control register at FFFA00 cleared by reset.
// - bit 1 selects bitmap half, bit 2 selects inverse video.
// - when disabled no reloads; shifter fills from the inverse bit.
module bdr_refresh
  import bdr_pkg::*;
#(
  parameter int SHIFT_WIDTH = 16
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [23:0] BUS_ADDR,
  input wire logic BUS_AV_N,
  input wire logic BUS_WR_STB,
  input wire logic [2:0] BUS_DATA,
  input wire logic GRANT_N,
  input wire logic REQUEST_CLEAR_N,
  input wire logic COL_STROBE_N,
  input wire logic [2*SHIFT_WIDTH-1:0] VRAM_DATA,
  output logic VMEM_SELECT_N,
  output logic XCVR_ENABLE_N,
  output logic [23:0] ADDR_O,
  output logic ADDR_OE,
  output logic ADDR_VALID_N_O,
  output logic ADDR_VALID_N_OE,
  output logic TRANSFER_OE_N,
  output logic REFRESH_REQ_N,
  output logic HSYNC_N,
  output logic VSYNC_N,
  output logic HBLANK,
  output logic VBLANK,
  output logic SHIFT_CLK,
  output logic LOW_HALF_OE_N,
  output logic HIGH_HALF_OE_N,
  output logic VIDEO_OUT
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // true while count lies in [start, start+len)
  function automatic logic in_window(input logic [9:0] count, input logic [9:0] start,
                                     input logic [9:0] len);
    in_window = (count >= start) && (count < start + len);
  endfunction : in_window

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [2:0] display_control;
  logic [2:0] next_display_control;
  logic display_on;
  logic negate_pixels;
  logic bitmap_half_select;
  logic dcr_hit;

  logic [3:0] pix_acc;
  logic [3:0] next_pix_acc;
  logic [4:0] pix_sum;
  logic pixel_clock;

  logic [3:0] dot_div;
  logic [3:0] next_dot_div;
  logic char_clock;
  logic shifter_load;

  logic [6:0] hcount;
  logic [6:0] next_hcount;
  logic [9:0] vcount;
  logic [9:0] next_vcount;
  logic hcount_zero_n;
  logic vcount_zero_n;
  logic vert_count_clk;

  logic line_fetch_req;
  logic row_fetch_req;
  logic fetch_request;
  logic [9:0] next_line;
  logic [6:0] row_count_bits;
  logic [6:0] next_row_count_bits;

  bdr_req_e req_state;
  bdr_req_e next_req_state;
  logic req_sync;
  logic next_req_sync;

  logic hsync_n;
  logic vsync_n;
  logic hblank;
  logic vblank;
  logic shift_clk;
  logic low_half_oe_n;
  logic next_hsync_n;
  logic next_vsync_n;
  logic next_hblank;
  logic next_vblank;
  logic next_shift_clk;
  logic next_low_half_oe_n;

  logic serial_pixel;
  logic [SHIFT_WIDTH-1:0] load_word;
  logic pix_q;
  logic blank_combined;
  logic video;
  logic next_pix_q;
  logic next_blank_combined;
  logic next_video;

  logic granted;
  logic mem_decode;

  // ----------------------------------------------------------------
  // control register, write only
  // ----------------------------------------------------------------

  // the register has no read path, so software must shadow its value
  assign dcr_hit = !BUS_AV_N && BUS_WR_STB && (BUS_ADDR == DCR_ADDR);
  assign display_on = !display_control[DCR_OFF_BIT];
  assign bitmap_half_select = display_control[DCR_HALF_BIT];
  assign negate_pixels = display_control[DCR_INV_BIT];

  always_comb begin
    next_display_control = display_control;
    if (dcr_hit) begin
      next_display_control = BUS_DATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      display_control <= DCR_RESET;
    end else begin
      display_control <= next_display_control;
    end
  end

  // ----------------------------------------------------------------
  // pixel rate enable
  // ----------------------------------------------------------------

  // fractional divider: 7 pulses per 10 core cycles averages 70 MHz,
  // trading a little pixel jitter for a single clock domain
  assign pix_sum = {1'b0, pix_acc} + {1'b0, PIX_STEP};
  assign pixel_clock = (pix_sum >= {1'b0, PIX_MOD});

  always_comb begin
    next_pix_acc = pix_sum[3:0];
    if (pixel_clock) begin
      next_pix_acc = 4'(pix_sum - {1'b0, PIX_MOD});
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pix_acc <= 4'h0;
    end else begin
      pix_acc <= next_pix_acc;
    end
  end

  // ----------------------------------------------------------------
  // character divider
  // ----------------------------------------------------------------
  assign char_clock = pixel_clock && (dot_div == 4'hF);
  assign shifter_load = char_clock;

  always_comb begin
    next_dot_div = dot_div;
    if (pixel_clock) begin
      next_dot_div = dot_div + 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dot_div <= 4'h0;
    end else begin
      dot_div <= next_dot_div;
    end
  end

  // ----------------------------------------------------------------
  // horizontal and vertical counters
  // ----------------------------------------------------------------
  assign hcount_zero_n = !(hcount == H_TOTAL - 7'h01);
  assign vcount_zero_n = !(vcount == V_TOTAL - 10'h001);
  assign vert_count_clk = char_clock && !hcount_zero_n;

  always_comb begin
    next_hcount = hcount;
    next_vcount = vcount;
    if (char_clock) begin
      next_hcount = hcount_zero_n ? hcount + 7'h01 : 7'h00;
    end
    if (vert_count_clk) begin
      next_vcount = vcount_zero_n ? vcount + 10'h001 : 10'h000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      hcount <= 7'h00;
      vcount <= 10'h000;
    end else begin
      hcount <= next_hcount;
      vcount <= next_vcount;
    end
  end

  // ----------------------------------------------------------------
  // fetch request decode
  // ----------------------------------------------------------------

  // the block for the next eight lines is fetched during the retrace
  // of the last line before it, so the shifter is ready at line start
  assign next_line = vcount_zero_n ? vcount + 10'h001 : 10'h000;
  assign row_fetch_req = (next_line[2:0] == 3'h0) &&
                         (next_line < V_ACTIVE);
  // one pulse per line: a level would re-arm after the clear
  assign line_fetch_req = char_clock && (next_hcount == H_FETCH);
  assign fetch_request = line_fetch_req && row_fetch_req;

  always_comb begin
    next_row_count_bits = row_count_bits;
    if (fetch_request && display_on) begin
      next_row_count_bits = next_line[9:3];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      row_count_bits <= 7'h00;
    end else begin
      row_count_bits <= next_row_count_bits;
    end
  end

  // ----------------------------------------------------------------
  // request handshake with the arbiter
  // ----------------------------------------------------------------

  // a new request in the clearing cycle wins over a clear taken in REQ_BUSY
  always_comb begin
    next_req_state = req_state;
    case (req_state)
      REQ_IDLE: begin
        if (fetch_request && display_on) begin
          next_req_state = REQ_WAIT;
        end
      end
      REQ_WAIT: begin
        if (!REQUEST_CLEAR_N) begin
          next_req_state = REQ_IDLE;
        end else if (!GRANT_N) begin
          next_req_state = REQ_BUSY;
        end
      end
      REQ_BUSY: begin
        if (!REQUEST_CLEAR_N) begin
          next_req_state = REQ_IDLE;
        end
      end
      default: begin
        next_req_state = REQ_IDLE;
      end
    endcase
    if (fetch_request && display_on && (req_state != REQ_WAIT)) begin
      next_req_state = REQ_WAIT;
    end
    // second stage before the arbiter; held through the grant, dropped at once on clear
    next_req_sync = (req_state != REQ_IDLE) && REQUEST_CLEAR_N;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      req_state <= REQ_IDLE;
      req_sync <= 1'b0;
    end else begin
      req_state <= next_req_state;
      req_sync <= next_req_sync;
    end
  end

  assign REFRESH_REQ_N = !req_sync;

  // ----------------------------------------------------------------
  // board select and address drive
  // ----------------------------------------------------------------
  assign granted = !GRANT_N;
  assign mem_decode = !BUS_AV_N && (BUS_ADDR[23:18] == VMEM_TAG);
  assign VMEM_SELECT_N = !(granted || mem_decode);
  assign XCVR_ENABLE_N = !(mem_decode && !granted);
  assign ADDR_OE = granted;
  assign ADDR_O = {6'h00, bitmap_half_select, row_count_bits, 2'b00, 8'h00};
  assign ADDR_VALID_N_OE = granted;
  assign ADDR_VALID_N_O = 1'b1;
  assign TRANSFER_OE_N = granted ? GRANT_N : COL_STROBE_N;

  // ----------------------------------------------------------------
  // timing waveforms
  // ----------------------------------------------------------------

  // registered so these waveforms leave from flip-flops together, HIGH_HALF_OE_N through an inverter of low_half_oe_n
  always_comb begin
    next_hblank = (hcount >= H_ACTIVE);
    next_vblank = (vcount >= V_ACTIVE);
    next_hsync_n = !in_window({3'h0, hcount}, {3'h0, H_SYNC_START},
                              {3'h0, H_SYNC_LEN});
    next_vsync_n = !in_window(vcount, V_SYNC_START, V_SYNC_LEN);
    // even characters take the low half, odd ones the high half
    next_low_half_oe_n = hcount[0];
    // advance the VRAM serial port once both halves are used
    next_shift_clk = shifter_load && hcount[0] && display_on;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      hblank <= 1'b1;
      vblank <= 1'b1;
      hsync_n <= 1'b1;
      vsync_n <= 1'b1;
      low_half_oe_n <= 1'b1;
      shift_clk <= 1'b0;
    end else begin
      hblank <= next_hblank;
      vblank <= next_vblank;
      hsync_n <= next_hsync_n;
      vsync_n <= next_vsync_n;
      low_half_oe_n <= next_low_half_oe_n;
      shift_clk <= next_shift_clk;
    end
  end

  assign HBLANK = hblank;
  assign VBLANK = vblank;
  assign HSYNC_N = hsync_n;
  assign VSYNC_N = vsync_n;
  assign LOW_HALF_OE_N = low_half_oe_n;
  assign HIGH_HALF_OE_N = !low_half_oe_n;
  assign SHIFT_CLK = shift_clk;

  // ----------------------------------------------------------------
  // video shifter
  // ----------------------------------------------------------------
  assign load_word = low_half_oe_n ? VRAM_DATA[2*SHIFT_WIDTH-1:SHIFT_WIDTH]
                                   : VRAM_DATA[SHIFT_WIDTH-1:0];

  // disabled display keeps the shifter unloaded, so the fill bit from
  // the inverse bit reaches the output and the screen stays dark
  bdr_shifter #(
    .WIDTH(SHIFT_WIDTH)
  ) u_shifter (
    .clk(CORE_CLK),
    .rst(RST),
    .load(shifter_load && display_on),
    .shift(pixel_clock),
    .data(load_word),
    .fill(negate_pixels),
    .serial_pixel(serial_pixel)
  );

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  always_comb begin
    next_pix_q = pix_q;
    next_blank_combined = blank_combined;
    if (pixel_clock) begin
      next_pix_q = serial_pixel;
      next_blank_combined = hblank || vblank;
    end
    // masking uses only the registered copies
    next_video = !blank_combined && (pix_q ^ negate_pixels);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pix_q <= 1'b0;
      blank_combined <= 1'b1;
      video <= 1'b0;
    end else begin
      pix_q <= next_pix_q;
      blank_combined <= next_blank_combined;
      video <= next_video;
    end
  end

  assign VIDEO_OUT = video;

endmodule : bdr_refresh

// ### verif/bdr_refresh_checker.sv
// bdr_refresh_checker: port-level checks of the display refresh controller.
// assumes one core clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module bdr_refresh_checker (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [23:0] BUS_ADDR,
  input wire logic BUS_AV_N,
  input wire logic GRANT_N,
  input wire logic REQUEST_CLEAR_N,
  input wire logic COL_STROBE_N,
  input wire logic VMEM_SELECT_N,
  input wire logic XCVR_ENABLE_N,
  input wire logic [23:0] ADDR_O,
  input wire logic ADDR_OE,
  input wire logic ADDR_VALID_N_O,
  input wire logic ADDR_VALID_N_OE,
  input wire logic TRANSFER_OE_N,
  input wire logic REFRESH_REQ_N,
  input wire logic HSYNC_N,
  input wire logic HBLANK,
  input wire logic VBLANK,
  input wire logic SHIFT_CLK,
  input wire logic LOW_HALF_OE_N,
  input wire logic HIGH_HALF_OE_N,
  input wire logic VIDEO_OUT
);
  // ------------------------------------------------------------
  // line length counter
  // ------------------------------------------------------------
  logic hs_prev;
  logic armed;
  logic [11:0] line_cyc;
  logic next_armed;
  logic [11:0] next_line_cyc;
  // restart at each sync fall; armed at the first fall, so only full lines are checked
  always_comb begin
    next_armed = armed | (hs_prev & ~HSYNC_N);
    next_line_cyc = (hs_prev & ~HSYNC_N) ? 12'h000 : line_cyc + 12'h001;
  end
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      hs_prev <= 1'b1;
      armed <= 1'b0;
      line_cyc <= 12'h000;
    end else begin
      hs_prev <= HSYNC_N;
      armed <= next_armed;
      line_cyc <= next_line_cyc;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence req_open; !REFRESH_REQ_N && REQUEST_CLEAR_N; endsequence
  sequence clear_taken; !REFRESH_REQ_N && !REQUEST_CLEAR_N; endsequence
  sequence blank_run; (HBLANK || VBLANK) [*4]; endsequence
  sequence half_swap; LOW_HALF_OE_N ##1 (!SHIFT_CLK && !LOW_HALF_OE_N); endsequence
  AST_SELECT_DECODE: assert property (
    VMEM_SELECT_N == !((!BUS_AV_N && BUS_ADDR[23:18] == 6'h38) || !GRANT_N))
    else $error("memory select differs from decode or grant");
  AST_GRANT_BUS: assert property (
    !GRANT_N |-> XCVR_ENABLE_N && ADDR_OE && ADDR_VALID_N_OE && ADDR_VALID_N_O)
    else $error("bus side wrong during grant");
  AST_GRANT_ADDR: assert property (
    !GRANT_N |-> ADDR_O[23:18] == 6'h00 && ADDR_O[9:0] == 10'h000)
    else $error("refresh address has stray bits");
  AST_TRANSFER_OE: assert property (
    TRANSFER_OE_N == (GRANT_N ? COL_STROBE_N : 1'b0))
    else $error("transfer enable follows wrong source");
  AST_REQ_HOLD: assert property (req_open |=> !REFRESH_REQ_N)
    else $error("request dropped without clear");
  AST_REQ_DROP: assert property (clear_taken |=> REFRESH_REQ_N)
    else $error("request held after clear");
  AST_SYNC_IN_BLANK: assert property (!HSYNC_N |-> HBLANK)
    else $error("line sync outside blanking");
  AST_HALF_ALTERNATE: assert property (LOW_HALF_OE_N != HIGH_HALF_OE_N)
    else $error("half enables not complementary");
  AST_BLANK_VIDEO: assert property (blank_run |-> !VIDEO_OUT)
    else $error("video active during blanking");
  AST_SHIFT_AFTER_HIGH: assert property (SHIFT_CLK |-> half_swap)
    else $error("shift clock not a pulse after the high half load");
  AST_LINE_PERIOD: assert property (
    armed && hs_prev && !HSYNC_N |-> line_cyc == 12'h77F)
    else $error("line length is not 1920 core cycles");
  cover property (clear_taken);
endmodule : bdr_refresh_checker

bind bdr_refresh bdr_refresh_checker bdr_refresh_checker_inst (.CORE_CLK(CORE_CLK), .RST(RST),
  .BUS_ADDR(BUS_ADDR), .BUS_AV_N(BUS_AV_N), .GRANT_N(GRANT_N), .REQUEST_CLEAR_N(REQUEST_CLEAR_N),
  .COL_STROBE_N(COL_STROBE_N), .VMEM_SELECT_N(VMEM_SELECT_N), .XCVR_ENABLE_N(XCVR_ENABLE_N),
  .ADDR_O(ADDR_O), .ADDR_OE(ADDR_OE), .ADDR_VALID_N_O(ADDR_VALID_N_O), .ADDR_VALID_N_OE(ADDR_VALID_N_OE),
  .TRANSFER_OE_N(TRANSFER_OE_N), .REFRESH_REQ_N(REFRESH_REQ_N), .HSYNC_N(HSYNC_N), .HBLANK(HBLANK),
  .VBLANK(VBLANK), .SHIFT_CLK(SHIFT_CLK), .LOW_HALF_OE_N(LOW_HALF_OE_N),
  .HIGH_HALF_OE_N(HIGH_HALF_OE_N), .VIDEO_OUT(VIDEO_OUT));

// ### verif/bdr_arbiter_model.sv
// bdr_arbiter_model: memory bus arbiter answering refresh requests.
// assumes requests are sampled on CORE_CLK; one refresh cycle at a time.
`timescale 1ns/1ns
module bdr_arbiter_model #(
  parameter int HOLD = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic REFRESH_REQ_N,
  input wire logic [3:0] grant_wait,
  output logic GRANT_N,
  output logic REQUEST_CLEAR_N
);
  // grant after a chosen wait so prompt and slow answers both occur
  initial begin
    GRANT_N = 1'b1;
    REQUEST_CLEAR_N = 1'b1;
    forever begin
      @(posedge CORE_CLK);
      if (!RST && REFRESH_REQ_N === 1'b0) begin
        repeat (grant_wait) @(posedge CORE_CLK);
        GRANT_N <= 1'b0;
        repeat (HOLD) @(posedge CORE_CLK);
        REQUEST_CLEAR_N <= 1'b0;
        @(posedge CORE_CLK);
        REQUEST_CLEAR_N <= 1'b1;
        GRANT_N <= 1'b1;
        @(posedge CORE_CLK);
      end
    end
  end
endmodule : bdr_arbiter_model

// ### verif/bdr_refresh_tb.sv
// bdr_refresh_tb: self-checking bench for the display refresh controller.
// assumes the arbiter model answers requests and the checker is bound.
`timescale 1ns/1ns
module bdr_refresh_tb;
  import bdr_pkg::*;
  typedef struct packed {logic [23:0] a; logic av_n; logic col_n; logic [2:0] exp;} bdr_row_s;
  // expected {select, transceiver, transfer enable}, all active low
  localparam bdr_row_s ROWS [6] = '{'{24'hE00000, 1'b0, 1'b1, 3'h1}, '{24'hE3FFFF, 1'b0, 1'b0, 3'h0},
    '{24'hE40000, 1'b0, 1'b1, 3'h7}, '{24'hDFFFFF, 1'b0, 1'b1, 3'h7},
    '{24'hE20000, 1'b1, 1'b0, 3'h6}, '{24'hFFFA00, 1'b0, 1'b1, 3'h7}};
  logic CORE_CLK, RST, BUS_AV_N, BUS_WR_STB, GRANT_N, REQUEST_CLEAR_N, COL_STROBE_N;
  logic [23:0] BUS_ADDR, ADDR_O;
  logic [2:0] BUS_DATA;
  logic [31:0] VRAM_DATA;
  logic [3:0] grant_wait;
  logic VMEM_SELECT_N, XCVR_ENABLE_N, ADDR_VALID_N_O, TRANSFER_OE_N, REFRESH_REQ_N;
  logic HSYNC_N, VSYNC_N, HBLANK, VBLANK, VIDEO_OUT, hs_prev, rq_prev;
  int err_total = 0;
  int num_checks = 0;
  int hs_falls = 0;
  int req_falls = 0;
  int n, m, base;

  bdr_refresh bdr_refresh_inst (.CORE_CLK, .RST, .BUS_ADDR, .BUS_AV_N, .BUS_WR_STB, .BUS_DATA,
    .GRANT_N, .REQUEST_CLEAR_N, .COL_STROBE_N, .VRAM_DATA, .VMEM_SELECT_N, .XCVR_ENABLE_N, .ADDR_O,
    .ADDR_OE(), .ADDR_VALID_N_O, .ADDR_VALID_N_OE(), .TRANSFER_OE_N, .REFRESH_REQ_N, .HSYNC_N,
    .VSYNC_N, .HBLANK, .VBLANK, .SHIFT_CLK(), .LOW_HALF_OE_N(), .HIGH_HALF_OE_N(), .VIDEO_OUT);
  bdr_arbiter_model bdr_arbiter_model_inst (.CORE_CLK, .RST, .REFRESH_REQ_N, .grant_wait,
    .GRANT_N, .REQUEST_CLEAR_N);

  // ------------------------------------------------------------
  // clock, edge counters and shared tasks
  // ------------------------------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  // counts line syncs since reset, so fetch lines can be located
  always @(posedge CORE_CLK) begin
    hs_prev <= HSYNC_N;
    rq_prev <= REFRESH_REQ_N;
    if (RST)
      hs_falls <= 0;
    else if (hs_prev === 1'b1 && HSYNC_N === 1'b0)
      hs_falls <= hs_falls + 1;
    if (rq_prev === 1'b1 && REFRESH_REQ_N === 1'b0)
      req_falls <= req_falls + 1;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic get_sig(input int sel);
    case (sel)
      0: return REFRESH_REQ_N;
      1: return GRANT_N;
      default: return HBLANK;
    endcase
  endfunction : get_sig
  // bounded wait on falling clock edges; a run-out counts as a mismatch
  task automatic wait_sig(input int sel, input logic lvl, input int limit, output int cnt);
    cnt = 0;
    while (get_sig(sel) !== lvl && cnt < limit) begin
      @(negedge CORE_CLK);
      cnt++;
    end
    if (cnt >= limit) begin
      err_total++;
      $display("CHECK FAILED t=%0t wait on %h ran out", $time, sel);
    end
  endtask : wait_sig
  // writes are held off while the arbiter has handed the bus to refresh
  task automatic bus_write(input logic [23:0] a, input logic [2:0] d);
    @(posedge CORE_CLK);
    while (GRANT_N !== 1'b1) @(posedge CORE_CLK);
    BUS_ADDR <= a;
    BUS_AV_N <= 1'b0;
    BUS_WR_STB <= 1'b1;
    BUS_DATA <= d;
    @(posedge CORE_CLK);
    BUS_AV_N <= 1'b1;
    BUS_WR_STB <= 1'b0;
  endtask : bus_write
  task automatic fetch_cycle(input int lines, input logic [23:0] addr);
    wait_sig(0, 1'b0, 20000, n);
    check(24'(hs_falls), 24'(lines));
    wait_sig(1, 1'b0, 40, n);
    @(negedge CORE_CLK);
    check(ADDR_O, addr);
    check(24'({VMEM_SELECT_N, XCVR_ENABLE_N, ADDR_VALID_N_O, TRANSFER_OE_N}), 24'h6);
    wait_sig(0, 1'b1, 40, n);
  endtask : fetch_cycle
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    RST = 1'b1;
    BUS_ADDR = 24'h000000;
    BUS_AV_N = 1'b1;
    BUS_WR_STB = 1'b0;
    BUS_DATA = 3'h0;
    COL_STROBE_N = 1'b1;
    VRAM_DATA = 32'h00000000;
    grant_wait = 4'h0;
    repeat (20) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    check(24'({REFRESH_REQ_N, HSYNC_N, VSYNC_N, HBLANK, VBLANK, VIDEO_OUT}), 24'h3E);
    @(posedge CORE_CLK);
    RST <= 1'b0;
    foreach (ROWS[i]) begin
      @(posedge CORE_CLK);
      BUS_ADDR <= ROWS[i].a;
      BUS_AV_N <= ROWS[i].av_n;
      COL_STROBE_N <= ROWS[i].col_n;
      @(negedge CORE_CLK);
      check(24'({VMEM_SELECT_N, XCVR_ENABLE_N, TRANSFER_OE_N}), 24'(ROWS[i].exp));
    end
    // an unmapped write carrying the disable bit must change nothing
    bus_write(24'hFFFA02, 3'h1);
    fetch_cycle(8, 24'h000400);
    bus_write(DCR_ADDR, 3'h2);
    grant_wait <= 4'h6;
    fetch_cycle(16, 24'h020800);
    wait_sig(2, 1'b0, 2000, n);
    wait_sig(2, 1'b1, 2000, n);
    wait_sig(2, 1'b0, 2000, m);
    check(24'(n + m), 24'h780);
    // video polarity over both data levels and both inverse settings
    for (int i = 0; i < 4; i++) begin
      bus_write(DCR_ADDR, {i[1], 2'b00});
      VRAM_DATA <= {32{i[0]}};
      wait_sig(2, 1'b1, 2000, n);
      wait_sig(2, 1'b0, 2000, n);
      repeat (300) @(negedge CORE_CLK);
      check(24'({VIDEO_OUT, VBLANK, VSYNC_N}), 24'({i[0] ^ i[1], 2'b01}));
      wait_sig(2, 1'b1, 2000, n);
      repeat (20) @(negedge CORE_CLK);
      check(24'(VIDEO_OUT), 24'h0);
    end
    // disabled and inverse: no request, and the unloaded shifter fills dark
    bus_write(DCR_ADDR, 3'h5);
    base = req_falls;
    VRAM_DATA <= 32'h00000000;
    wait_sig(2, 1'b1, 2000, n);
    wait_sig(2, 1'b0, 2000, n);
    repeat (300) @(negedge CORE_CLK);
    check(24'(VIDEO_OUT), 24'h0);
    n = 0;
    while (hs_falls < 33 && n < 40000) begin
      @(negedge CORE_CLK);
      n++;
    end
    check(24'(hs_falls), 24'h21);
    check(24'(req_falls - base), 24'h0);
    @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (20) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    check(24'({REFRESH_REQ_N, HBLANK, VIDEO_OUT}), 24'h6);
    @(posedge CORE_CLK);
    RST <= 1'b0;
    // reset must clear the register, which enables requests again
    fetch_cycle(8, 24'h000400);
    report_and_stop();
  end

  initial begin
    repeat (90000) @(posedge CORE_CLK);
    err_total++;
    $display("watchdog expired t=%0t", $time);
    report_and_stop();
  end
endmodule : bdr_refresh_tb
